/* File: dapwm_pkg.sv */
package dapwm_pkg;
   // ==========================================================
   // Register map (word addresses, byte address = 4 * index)
   // ==========================================================
   localparam logic [3:0] ADDR_PERIOD_0   = 4'h0;
   localparam logic [3:0] ADDR_PERIOD_1   = 4'h1;
   localparam logic [3:0] ADDR_ON_TIME_0  = 4'h2;
   localparam logic [3:0] ADDR_ON_TIME_1  = 4'h3;
   localparam logic [3:0] ADDR_MODE_CTRL  = 4'h4;
   localparam logic [3:0] ADDR_STATUS     = 4'h5;
   localparam int         ADDR_WIDTH      = 4;

   // ==========================================================
   // Field layout and reset values
   // ==========================================================
   localparam int         MODE_SEL_BIT    = 8;
   localparam logic [7:0] RST_PERIOD      = 8'hFF;
   localparam logic [7:0] RST_ON_TIME     = 8'h00;
   localparam logic       RST_MODE_SEL    = 1'b0;
   localparam int         STEP_CYCLES     = 2;
   localparam logic [31:0] UNMAPPED_DATA  = 32'h0000_0000;

   // ==========================================================
   // Types
   // ==========================================================
   typedef enum logic {
      DAPWM_BUS_IDLE,
      DAPWM_BUS_DONE
   } dapwm_bus_t;
endpackage

/* File: dapwm_step.sv */
`timescale 1ns/1ps
// Divides the clock into one-cycle time-step pulses, every STEP clocks.
module dapwm_step #(
   parameter int STEP = 2
) (
   input  wire logic mclk,
   input  wire logic rst,
   input  wire logic restart,
   output logic      tick
);
   typedef struct packed {
      logic [7:0] cnt;
      logic       tick;
   } dapwm_step_t;

   dapwm_step_t st;
   dapwm_step_t next_st;
   logic [7:0]  cur;

   // Count to STEP and pulse; a restart acts as a step boundary so the
   // first step after it is no longer than any other
   always_comb begin
      next_st      = st;
      next_st.tick = 1'b0;
      cur          = restart ? 8'h00 : st.cnt;
      if (cur == 8'(STEP - 1)) begin
         next_st.cnt  = 8'h00;
         next_st.tick = 1'b1;
      end else begin
         next_st.cnt = cur + 8'h01;
      end
   end

   // State register
   always_ff @(posedge mclk) begin
      if (rst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign tick = st.tick;
endmodule // dapwm_step

/* File: dapwm_chan.sv */
`timescale 1ns/1ps
// One PWM channel: cycle counter in steps, on-time latched at cycle start.
module dapwm_chan (
   input  wire logic       mclk,
   input  wire logic       rst,
   input  wire logic       tick,
   input  wire logic       restart,
   input  wire logic       start,
   input  wire logic       use_start,
   input  wire logic [7:0] period,
   input  wire logic [7:0] on_time,
   output logic            cyc_start,
   output logic            pwm
);
   typedef struct packed {
      logic [7:0] cnt;
      logic [7:0] on_lat;
      logic       run;
      logic       pwm;
   } dapwm_chan_t;

   dapwm_chan_t st;
   dapwm_chan_t next_st;
   logic        wrap;
   logic [7:0]  pos;

   // Cycle start from restart, or from own wrap or external start pulse;
   // a period lowered below the count ends the cycle at the next step
   assign wrap      = tick && (st.cnt >= period);
   assign cyc_start = restart || (use_start ? start : wrap);

   // Counter, latch and output
   always_comb begin
      next_st = st;
      pos     = 8'h00;
      if (cyc_start) begin
         next_st.cnt    = 8'h00;
         next_st.on_lat = on_time;
         next_st.run    = 1'b1;
         pos            = 8'h00;
      end else if (tick) begin
         next_st.cnt = st.cnt + 8'h01;
         pos         = st.cnt + 8'h01;
      end else begin
         pos = st.cnt;
      end
      // High for on_lat steps from cycle start, full if on_lat > period
      if (cyc_start) begin
         next_st.pwm = (on_time != 8'h00);
      end else if (st.run) begin
         next_st.pwm = (pos < st.on_lat) || (st.on_lat > period);
      end
   end

   // State register
   always_ff @(posedge mclk) begin
      if (rst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign pwm = st.pwm;
endmodule // dapwm_chan

/* File: dual_aux_pwm_timer.sv */
// Chosen here: register access over Avalon-MM and the register addresses.
`timescale 1ns/1ps
module dual_aux_pwm_timer
   import dapwm_pkg::*;
#(
   parameter int STEP = dapwm_pkg::STEP_CYCLES
) (
   input  wire logic                             mclk,
   input  wire logic                             rst,
   input  wire logic [dapwm_pkg::ADDR_WIDTH-1:0] avs_address,
   input  wire logic                             avs_read,
   input  wire logic                             avs_write,
   input  wire logic [31:0]                      avs_writedata,
   input  wire logic [3:0]                       avs_byteenable,
   output logic [31:0]                           avs_readdata,
   output logic                                  avs_waitrequest,
   output logic                                  aux_pwm_out_zero,
   output logic                                  aux_pwm_out_one
);
   import dapwm_pkg::*;

   // ==========================================================
   // State
   // ==========================================================
   typedef struct packed {
      logic [7:0]  aux_period_0;
      logic [7:0]  aux_period_1_or_offset;
      logic [7:0]  aux_on_time_0;
      logic [7:0]  aux_on_time_1;
      logic        mode_sel;
      dapwm_bus_t  bus;
      logic [31:0] rdata;
      logic        restart;
      logic        off_arm;
      logic [7:0]  off_cnt;
      logic        out0;
      logic        out1;
   } dapwm_top_t;

   dapwm_top_t st;
   dapwm_top_t next_st;

   logic       tick;
   logic       start0;
   logic       start1;
   logic       pwm0;
   logic       pwm1;
   logic       indep;
   logic [7:0] period1_eff;
   logic       off_fire;
   logic       wr_acc;
   logic       rd_acc;

   assign indep       = st.mode_sel;
   assign period1_eff = indep ? st.aux_period_1_or_offset : st.aux_period_0;
   assign wr_acc      = avs_write && (st.bus == DAPWM_BUS_IDLE);
   assign rd_acc      = avs_read && (st.bus == DAPWM_BUS_IDLE);
   assign off_fire    = st.off_arm && tick && (st.off_cnt == st.aux_period_1_or_offset);

   // ==========================================================
   // Time step and channels
   // ==========================================================
   dapwm_step #(
      .STEP (STEP)
   ) u_step (
      .mclk    (mclk),
      .rst     (rst),
      .restart (st.restart),
      .tick    (tick)
   );

   dapwm_chan u_ch0 (
      .mclk      (mclk),
      .rst       (rst),
      .tick      (tick),
      .restart   (st.restart),
      .start     (1'b0),
      .use_start (1'b0),
      .period    (st.aux_period_0),
      .on_time   (st.aux_on_time_0),
      .cyc_start (start0),
      .pwm       (pwm0)
   );

   dapwm_chan u_ch1 (
      .mclk      (mclk),
      .rst       (rst),
      .tick      (tick),
      .restart   (st.restart),
      .start     (off_fire),
      .use_start (!indep),
      .period    (period1_eff),
      .on_time   (st.aux_on_time_1),
      .cyc_start (start1),
      .pwm       (pwm1)
   );

   // ==========================================================
   // Register file, offset timer and output staging
   // ==========================================================
   always_comb begin
      next_st         = st;
      next_st.restart = 1'b0;
      next_st.out0    = pwm0;
      next_st.out1    = pwm1;

      // Bus handshake: one wait cycle, then acknowledge
      if (st.bus == DAPWM_BUS_DONE) begin
         next_st.bus = DAPWM_BUS_IDLE;
      end else if (avs_read || avs_write) begin
         next_st.bus = DAPWM_BUS_DONE;
      end

      // Writes, low byte lane for 8-bit fields, byte 1 for the mode bit
      if (wr_acc) begin
         if (avs_address == ADDR_PERIOD_0) begin
            if (avs_byteenable[0]) begin
               next_st.aux_period_0 = avs_writedata[7:0];
               next_st.restart      = indep;
            end
         end else if (avs_address == ADDR_PERIOD_1) begin
            if (avs_byteenable[0]) begin
               next_st.aux_period_1_or_offset = avs_writedata[7:0];
               next_st.restart                = indep;
            end
         end else if (avs_address == ADDR_ON_TIME_0) begin
            if (avs_byteenable[0]) begin
               next_st.aux_on_time_0 = avs_writedata[7:0];
            end
         end else if (avs_address == ADDR_ON_TIME_1) begin
            if (avs_byteenable[0]) begin
               next_st.aux_on_time_1 = avs_writedata[7:0];
            end
         end else if (avs_address == ADDR_MODE_CTRL) begin
            if (avs_byteenable[1]) begin
               next_st.mode_sel = avs_writedata[MODE_SEL_BIT];
            end
         end
      end

      // Reads, latched for the acknowledge cycle
      if (rd_acc) begin
         next_st.rdata = UNMAPPED_DATA;
         if (avs_address == ADDR_PERIOD_0) begin
            next_st.rdata[7:0] = st.aux_period_0;
         end else if (avs_address == ADDR_PERIOD_1) begin
            next_st.rdata[7:0] = st.aux_period_1_or_offset;
         end else if (avs_address == ADDR_ON_TIME_0) begin
            next_st.rdata[7:0] = st.aux_on_time_0;
         end else if (avs_address == ADDR_ON_TIME_1) begin
            next_st.rdata[7:0] = st.aux_on_time_1;
         end else if (avs_address == ADDR_MODE_CTRL) begin
            next_st.rdata[MODE_SEL_BIT] = st.mode_sel;
         end else if (avs_address == ADDR_STATUS) begin
            next_st.rdata[0] = st.out0;
            next_st.rdata[1] = st.out1;
            next_st.rdata[2] = st.off_arm;
         end
      end

      // Offset delay: counts (offset + 1) steps from channel zero start
      if (st.restart || indep) begin
         next_st.off_arm = 1'b0;
         next_st.off_cnt = 8'h00;
      end else if (start0) begin
         next_st.off_arm = 1'b1;
         next_st.off_cnt = 8'h00;
      end else if (off_fire) begin
         next_st.off_arm = 1'b0;
      end else if (st.off_arm && tick) begin
         next_st.off_cnt = st.off_cnt + 8'h01;
      end
   end

   // State register with documented reset values
   always_ff @(posedge mclk) begin
      if (rst) begin
         st                        <= '0;
         st.aux_period_0           <= RST_PERIOD;
         st.aux_period_1_or_offset <= RST_PERIOD;
         st.aux_on_time_0          <= RST_ON_TIME;
         st.aux_on_time_1          <= RST_ON_TIME;
         st.mode_sel               <= RST_MODE_SEL;
         st.bus                    <= DAPWM_BUS_IDLE;
      end else begin
         st <= next_st;
      end
   end

   // Outputs straight from flip-flops
   assign aux_pwm_out_zero = st.out0;
   assign aux_pwm_out_one  = st.out1;
   assign avs_readdata     = st.rdata;
   assign avs_waitrequest  = !(st.bus == DAPWM_BUS_DONE);
endmodule // dual_aux_pwm_timer

/* File: dapwm_sva.sv */
`timescale 1ns/1ps
// ==========================================
// Bus and waveform checks
module dapwm_sva
   import dapwm_pkg::*;
#(
   parameter int STEP = 2
) (
   input wire logic                             mclk,
   input wire logic                             rst,
   input wire logic [dapwm_pkg::ADDR_WIDTH-1:0] avs_address,
   input wire logic                             avs_read,
   input wire logic                             avs_write,
   input wire logic [31:0]                      avs_writedata,
   input wire logic [3:0]                       avs_byteenable,
   input wire logic [31:0]                      avs_readdata,
   input wire logic                             avs_waitrequest,
   input wire logic                             aux_pwm_out_zero,
   input wire logic                             aux_pwm_out_one
);
   logic [7:0]  sh [4];
   logic        sh_mode, q0, done_wr, rd_ok;
   logic [11:0] age, hi0, pc0;
   int          lim;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);
   // Completed accesses; settle time after the last write
   assign done_wr = avs_write && !avs_waitrequest;
   assign rd_ok = avs_read && !avs_waitrequest;
   assign lim = 2 * STEP * (sh[0] + sh[1] + 2) + 8;
   // Shadow registers and waveform counters
   always_ff @(posedge mclk) begin
      if (rst) begin
         sh <= '{RST_PERIOD, RST_PERIOD, RST_ON_TIME, RST_ON_TIME};
         sh_mode <= RST_MODE_SEL;
         age <= 12'h000;
      end else begin
         if (done_wr && avs_byteenable[0] && avs_address < ADDR_MODE_CTRL) begin
            sh[avs_address[1:0]] <= avs_writedata[7:0];
         end
         if (done_wr && avs_byteenable[1] && avs_address == ADDR_MODE_CTRL) begin
            sh_mode <= avs_writedata[MODE_SEL_BIT];
         end
         age <= done_wr ? 12'h000 : age + {11'h000, age != 12'hFFF};
      end
      q0 <= aux_pwm_out_zero;
      hi0 <= aux_pwm_out_zero ? hi0 + 12'h001 : 12'h000;
      pc0 <= (aux_pwm_out_zero && !q0) ? 12'h001 : pc0 + 12'h001;
   end
   chk_wait_answer: assert property ((avs_read || avs_write) && avs_waitrequest
      |=> !avs_waitrequest) else $error("access not answered");
   chk_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("waitrequest low too long");
   chk_read_value: assert property (rd_ok && avs_address < ADDR_MODE_CTRL
      |-> avs_readdata == {24'h000000, sh[avs_address[1:0]]}) else $error("bad read");
   chk_mode_read: assert property (rd_ok && avs_address == ADDR_MODE_CTRL
      |-> avs_readdata[MODE_SEL_BIT] == sh_mode) else $error("bad mode read");
   chk_unmapped_read: assert property (rd_ok && avs_address > ADDR_STATUS
      |-> avs_readdata == UNMAPPED_DATA) else $error("bad unmapped read");
   chk_reset_idle: assert property ($fell(rst) |-> avs_waitrequest && !aux_pwm_out_zero
      && !aux_pwm_out_one) else $error("not idle after reset");
   chk_high_time: assert property ($fell(aux_pwm_out_zero) && age > lim
      |-> hi0 == STEP * sh[2]) else $error("bad on-time");
   chk_period_zero: assert property ($rose(aux_pwm_out_zero) && age > lim
      |-> pc0 == STEP * (sh[0] + 1)) else $error("bad period");
   chk_offset_lag: assert property ($rose(aux_pwm_out_one) && !sh_mode && age > lim
      && sh[2] != 0 && sh[2] <= sh[0] && sh[1] < sh[0]
      |-> pc0 == STEP * (sh[1] + 1)) else $error("bad lag");
   chk_period_restart: assert property (done_wr && avs_byteenable[0] && sh_mode
      && avs_address <= ADDR_PERIOD_1 && sh[2] != 0 |-> ##[1:4] aux_pwm_out_zero)
      else $error("no restart");
   cover property (rd_ok && avs_address > ADDR_STATUS);
   cover property ($rose(aux_pwm_out_one) && !sh_mode && age > lim);
   cover property (done_wr && sh_mode && avs_address == ADDR_PERIOD_0);
endmodule // dapwm_sva

bind dual_aux_pwm_timer dapwm_sva #(.STEP(STEP)) i_sva (
   .mclk(mclk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
   .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
   .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
   .aux_pwm_out_zero(aux_pwm_out_zero), .aux_pwm_out_one(aux_pwm_out_one));

/* File: dapwm_load.sv */
`timescale 1ns/1ps
// ==========================================
// Load side monitor
// Measures pulse width, period and lag behind a reference pin, in clocks
module dapwm_load (
   input  wire logic   mclk,
   input  wire logic   rst,
   input  wire logic   pin,
   input  wire logic   ref_pin,
   output logic [15:0] hi_len,
   output logic [15:0] per_len,
   output logic [15:0] lag_len
);
   logic        q_pin, q_ref;
   logic [15:0] hc, pc, lc;
   // Edge detection and run counters
   always_ff @(posedge mclk) begin
      if (rst) begin
         {q_pin, q_ref, hc, pc, lc, hi_len, per_len, lag_len} <= '0;
      end else begin
         q_pin <= pin;
         q_ref <= ref_pin;
         hc <= pin ? hc + 16'h0001 : 16'h0000;
         pc <= (pin && !q_pin) ? 16'h0001 : pc + 16'h0001;
         lc <= (ref_pin && !q_ref) ? 16'h0001 : lc + 16'h0001;
         if (pin && !q_pin) begin
            per_len <= pc;
            lag_len <= lc;
         end
         if (!pin && q_pin) hi_len <= hc;
      end
   end
endmodule // dapwm_load

/* File: dual_aux_pwm_timer_test.sv */
`timescale 1ns/1ps
// ==========================================
// Register and waveform tests
module dual_aux_pwm_timer_test;
   import dapwm_pkg::*;
   logic        mclk = 1'b0;
   logic        rst = 1'b1;
   logic [3:0]  avs_address = 4'h0;
   logic        avs_read = 1'b0;
   logic        avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [3:0]  avs_byteenable = 4'hF;
   logic [31:0] avs_readdata, q;
   logic        avs_waitrequest, out0, out1;
   logic [15:0] hi0, per0, hi1, per1, lag1;
   int          err_total = 0;
   int          checks = 0;
   // Clock and design
   always #50 mclk = ~mclk;
   dual_aux_pwm_timer i_dut (.mclk(mclk), .rst(rst), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .aux_pwm_out_zero(out0), .aux_pwm_out_one(out1));
   dapwm_load i_load0 (.mclk(mclk), .rst(rst), .pin(out0), .ref_pin(out0),
      .hi_len(hi0), .per_len(per0), .lag_len());
   dapwm_load i_load1 (.mclk(mclk), .rst(rst), .pin(out1), .ref_pin(out0),
      .hi_len(hi1), .per_len(per1), .lag_len(lag1));
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e) begin
         err_total++;
         $display("unexpected %s expected %h seen %h", nm, e, g);
      end
   endtask
   // One Avalon access, held until waitrequest is sampled low
   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
                      input logic [3:0] be);
      @(posedge mclk);
      avs_address <= a;
      avs_writedata <= d;
      avs_byteenable <= be;
      avs_write <= w;
      avs_read <= !w;
      // Only the watchdog ends a wait that never completes
      do begin
         @(posedge mclk);
      end while (avs_waitrequest !== 1'b0);
      q = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      bus(1'b1, a, d, 4'hF);
   endtask
   task automatic rd(input string nm, input logic [3:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0, 4'hF);
      chk(nm, e, q);
   endtask
   task automatic steady(input string nm, input logic one, input logic e);
      for (int i = 0; i < 12; i++) begin
         @(posedge mclk);
         chk(nm, {31'h0, e}, {31'h0, one ? out1 : out0});
      end
   endtask
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", checks, err_total);
      if (err_total == 0 && checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   // Watchdog
   initial begin
      #(100 * 5000);
      err_total++;
      print_verdict();
   end
   // Main sequence
   initial begin
      repeat (16) @(posedge mclk);
      rst <= 1'b0;
      rd("period_0", ADDR_PERIOD_0, 32'hFF);
      rd("period_1", ADDR_PERIOD_1, 32'hFF);
      rd("on_time_0", ADDR_ON_TIME_0, 32'h0);
      rd("on_time_1", ADDR_ON_TIME_1, 32'h0);
      bus(1'b0, ADDR_MODE_CTRL, 32'h0, 4'hF);
      chk("mode", 32'h0, {31'h0, q[MODE_SEL_BIT]});
      rd("status", ADDR_STATUS, 32'h0);
      wr(4'hF, 32'hAA);
      rd("unmapped", 4'hF, UNMAPPED_DATA);
      bus(1'b1, ADDR_PERIOD_1, 32'h07, 4'h2);
      rd("gated", ADDR_PERIOD_1, 32'hFF);
      $display("test registers done");
      wr(ADDR_MODE_CTRL, 32'h100);
      wr(ADDR_PERIOD_0, 32'h09);
      wr(ADDR_ON_TIME_0, 32'h03);
      wr(ADDR_PERIOD_1, 32'h04);
      wr(ADDR_ON_TIME_1, 32'h05);
      repeat (80) @(posedge mclk);
      chk("hi_0", 32'h6, {16'h0, hi0});
      chk("per_0", 32'h14, {16'h0, per0});
      steady("out_1 full", 1'b1, 1'b1);
      wr(ADDR_ON_TIME_0, 32'h07);
      repeat (60) @(posedge mclk);
      chk("hi_0 new", 32'hE, {16'h0, hi0});
      wr(ADDR_PERIOD_0, 32'h13);
      repeat (100) @(posedge mclk);
      chk("per_0 new", 32'h28, {16'h0, per0});
      wr(ADDR_ON_TIME_0, 32'h00);
      repeat (60) @(posedge mclk);
      steady("out_0 zero", 1'b0, 1'b0);
      $display("test independent done");
      wr(ADDR_MODE_CTRL, 32'h0);
      wr(ADDR_PERIOD_0, 32'h09);
      wr(ADDR_PERIOD_1, 32'h03);
      wr(ADDR_ON_TIME_0, 32'h02);
      wr(ADDR_ON_TIME_1, 32'h02);
      repeat (100) @(posedge mclk);
      chk("lag_1", 32'h8, {16'h0, lag1});
      chk("per_1", 32'h14, {16'h0, per1});
      chk("hi_1", 32'h4, {16'h0, hi1});
      $display("test offset done");
      print_verdict();
   end
endmodule // dual_aux_pwm_timer_test
